// [inc/tgd_pkg.sv]
// Constants and carrier types for the task gate and long task state block decoder.
// Assumes a 32-bit word memory port that returns aligned little-endian words.
package tgd_pkg;
  // 64-bit task state block layout (byte offsets)
  localparam logic [7:0] TGD_OFS_PSP0     = 8'h04;
  localparam logic [7:0] TGD_OFS_IST1     = 8'h24;
  localparam logic [7:0] TGD_OFS_MAP_WORD = 8'h64;
  localparam logic [7:0] TGD_PTR_STRIDE   = 8'h08;
  localparam logic [7:0] TGD_WORD_BYTES   = 8'h04;
  localparam int         TGD_MAP_LSB      = 16;
  // Task gate upper word fields
  localparam int         TGD_P_BIT        = 15;
  localparam int         TGD_DPL_MSB      = 14;
  localparam int         TGD_DPL_LSB      = 13;
  localparam int         TGD_ST_MSB       = 12;
  localparam int         TGD_ST_LSB       = 8;
  localparam logic [4:0] TGD_TASK_GATE    = 5'h05;
  // Task gate lower word selector field
  localparam int         TGD_SEL_MSB      = 31;
  localparam int         TGD_SEL_LSB      = 16;

  typedef enum logic [1:0] {
    TGD_TBL_GLOBAL = 2'h0,
    TGD_TBL_LOCAL  = 2'h1,
    TGD_TBL_INTR   = 2'h2
  } tgd_table_t;

  typedef struct packed {
    logic        present;
    logic [1:0]  descriptor_privilege_level;
    logic        is_task_gate;
    logic [15:0] tsb_selector;
    tgd_table_t  table_id;
  } tgd_gate_t;

  typedef struct packed {
    logic [15:0] port;
    logic [2:0]  size;
  } tgd_io_req_t;
endpackage

// [rtl/tgd_decoder.sv]
// Task gate decode, long task state block field fetch, io permission check,
// and per-task local table selector / page table base tracking.
// Assumes a single core clock and a memory port answering with i_mem_ack.
`timescale 1ns/100ps
module tgd_decoder
  import tgd_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_long_mode,
  input  wire logic              i_paging_en,
  input  wire logic              i_desc_valid,
  input  wire logic              i_desc_xfer,
  input  wire tgd_table_t        i_desc_table,
  input  wire logic [31:0]       i_desc_lo,
  input  wire logic [31:0]       i_desc_hi,
  input  wire logic [ADDR_W-1:0] i_tsb_base,
  input  wire logic [15:0]       i_tsb_limit,
  input  wire logic              i_stk_req,
  input  wire logic              i_stk_ist,
  input  wire logic [2:0]        i_stk_idx,
  input  wire logic              i_io_req,
  input  wire tgd_io_req_t       i_io,
  output logic                   o_mem_req,
  output logic [ADDR_W-1:0]      o_mem_addr,
  input  wire logic              i_mem_ack,
  input  wire logic [31:0]       i_mem_rdata,
  input  wire logic              i_task_switch,
  input  wire logic [15:0]       i_new_ldt_sel,
  input  wire logic [ADDR_W-1:0] i_new_ptb,
  input  wire logic              i_xlat_req,
  input  wire logic [ADDR_W-1:0] i_lin_addr,
  output tgd_gate_t              o_gate,
  output logic                   o_gate_valid,
  output logic                   o_np_fault,
  output logic                   o_gp_fault,
  output logic                   o_busy,
  output logic [63:0]            o_stack_ptr,
  output logic                   o_stk_done,
  output logic                   o_io_done,
  output logic                   o_io_grant,
  output logic                   o_save_valid,
  output logic [15:0]            o_saved_ldt_sel,
  output logic [ADDR_W-1:0]      o_saved_ptb,
  output logic [15:0]            o_ldt_sel,
  output logic [ADDR_W-1:0]      o_ptb,
  output logic                   o_walk_req,
  output logic [ADDR_W-1:0]      o_walk_root,
  output logic                   o_phys_valid,
  output logic [ADDR_W-1:0]      o_phys_addr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] size_mask(input logic [2:0] size);
    case (size)
      3'h1:    size_mask = 4'h1;
      3'h2:    size_mask = 4'h3;
      default: size_mask = 4'hf;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] ext8(input logic [7:0] v);
    ext8 = {{(ADDR_W-8){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------
  // Task gate decode
  // ----------------------------------------------------------------
  tgd_gate_t gate_now;
  always_comb begin
    // Reserved low byte, upper half and lower half are never looked at
    gate_now.present      = i_desc_hi[TGD_P_BIT];
    gate_now.descriptor_privilege_level          = i_desc_hi[TGD_DPL_MSB:TGD_DPL_LSB];
    gate_now.is_task_gate = (i_desc_hi[TGD_ST_MSB:TGD_ST_LSB] == TGD_TASK_GATE);
    gate_now.tsb_selector = i_desc_lo[TGD_SEL_MSB:TGD_SEL_LSB];
    gate_now.table_id     = i_desc_table;
  end

  logic gate_gp;
  logic gate_np;
  assign gate_gp = i_desc_valid && i_desc_xfer && i_long_mode && gate_now.is_task_gate;
  assign gate_np = i_desc_valid && gate_now.is_task_gate && !gate_now.present && !gate_gp;

  // Descriptor is only read; no write path back to memory exists
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gate       <= '0;
      o_gate_valid <= 1'b0;
      o_np_fault   <= 1'b0;
    end else begin
      o_gate_valid <= i_desc_valid;
      o_np_fault   <= gate_np;
      if (i_desc_valid) begin
        o_gate <= gate_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // Task state block fetch engine
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    TGD_IDLE  = 6'h01,
    TGD_STK_L = 6'h02,
    TGD_STK_H = 6'h04,
    TGD_MAP_B = 6'h08,
    TGD_IO_L  = 6'h10,
    TGD_IO_H  = 6'h20
  } tgd_state_t;

  tgd_state_t  state;
  logic [31:0] lo_word;
  tgd_io_req_t io_hold;
  logic [15:0] map_byte;
  logic [16:0] next_map_byte;
  logic [5:0]  bit_shift;
  logic [63:0] map_pair;
  logic [3:0]  map_bits;
  logic        io_deny;
  logic        io_gp;
  logic        io_oob;

  assign next_map_byte = {1'b0, i_mem_rdata[31:TGD_MAP_LSB]} + {4'h0, io_hold.port[15:3]};
  // Two bytes are read so multi-byte ports crossing a byte still see every bit
  assign io_oob    = (next_map_byte + 17'h1) > {1'b0, i_tsb_limit};
  assign bit_shift = {map_byte[1:0], 3'h0} + {3'h0, io_hold.port[2:0]};
  assign map_pair  = {i_mem_rdata, lo_word} >> bit_shift;
  assign map_bits  = map_pair[3:0] & size_mask(io_hold.size);
  assign io_deny   = |map_bits;
  assign io_gp     = ((state == TGD_IO_H) && i_mem_ack && io_deny) ||
                     ((state == TGD_MAP_B) && i_mem_ack && io_oob);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state       <= TGD_IDLE;
      o_mem_req   <= 1'b0;
      o_mem_addr  <= '0;
      lo_word     <= '0;
      io_hold     <= '0;
      map_byte    <= '0;
      o_stack_ptr <= '0;
      o_stk_done  <= 1'b0;
      o_io_done   <= 1'b0;
      o_io_grant  <= 1'b0;
    end else begin
      o_stk_done <= 1'b0;
      o_io_done  <= 1'b0;
      case (state)
        TGD_IDLE: begin
          if (i_stk_req) begin
            o_mem_req <= 1'b1;
            if (i_stk_ist) begin
              o_mem_addr <= i_tsb_base + ext8(TGD_OFS_IST1) +
                            ext8(TGD_PTR_STRIDE * {5'h0, i_stk_idx - 3'h1});
            end else begin
              o_mem_addr <= i_tsb_base + ext8(TGD_OFS_PSP0) +
                            ext8(TGD_PTR_STRIDE * {5'h0, i_stk_idx});
            end
            state <= TGD_STK_L;
          end else if (i_io_req) begin
            o_mem_req  <= 1'b1;
            o_mem_addr <= i_tsb_base + ext8(TGD_OFS_MAP_WORD);
            io_hold    <= i_io;
            state      <= TGD_MAP_B;
          end
        end
        TGD_STK_L: begin
          if (i_mem_ack) begin
            lo_word    <= i_mem_rdata;
            o_mem_addr <= o_mem_addr + ext8(TGD_WORD_BYTES);
            state      <= TGD_STK_H;
          end
        end
        TGD_STK_H: begin
          if (i_mem_ack) begin
            o_stack_ptr <= {i_mem_rdata, lo_word};
            o_stk_done  <= 1'b1;
            o_mem_req   <= 1'b0;
            state       <= TGD_IDLE;
          end
        end
        TGD_MAP_B: begin
          if (i_mem_ack) begin
            if (io_oob) begin
              // Ports beyond the block limit behave as if their bit were set
              o_io_done  <= 1'b1;
              o_io_grant <= 1'b0;
              o_mem_req  <= 1'b0;
              state      <= TGD_IDLE;
            end else begin
              map_byte   <= next_map_byte[15:0];
              o_mem_addr <= i_tsb_base + {{(ADDR_W-16){1'b0}}, next_map_byte[15:2], 2'h0};
              state      <= TGD_IO_L;
            end
          end
        end
        TGD_IO_L: begin
          if (i_mem_ack) begin
            lo_word    <= i_mem_rdata;
            o_mem_addr <= o_mem_addr + ext8(TGD_WORD_BYTES);
            state      <= TGD_IO_H;
          end
        end
        TGD_IO_H: begin
          if (i_mem_ack) begin
            o_io_done  <= 1'b1;
            o_io_grant <= !io_deny;
            o_mem_req  <= 1'b0;
            state      <= TGD_IDLE;
          end
        end
        default: begin
          state     <= TGD_IDLE;
          o_mem_req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state != TGD_IDLE) || i_stk_req || i_io_req;
    end
  end

  // ----------------------------------------------------------------
  // Per-task state and legacy switch
  // ----------------------------------------------------------------
  logic switch_gp;
  assign switch_gp = i_task_switch && i_long_mode;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_save_valid    <= 1'b0;
      o_saved_ldt_sel <= '0;
      o_saved_ptb     <= '0;
      o_ldt_sel       <= '0;
      o_ptb           <= '0;
    end else begin
      // In long mode nothing is saved or restored; software owns that state
      o_save_valid <= i_task_switch && !i_long_mode;
      if (i_task_switch && !i_long_mode) begin
        o_saved_ldt_sel <= o_ldt_sel;
        o_ldt_sel       <= i_new_ldt_sel;
        o_saved_ptb     <= o_ptb;
        o_ptb           <= i_new_ptb;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gp_fault <= 1'b0;
    end else begin
      o_gp_fault <= gate_gp || switch_gp || io_gp;
    end
  end

  // ----------------------------------------------------------------
  // Translation root selection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_walk_req   <= 1'b0;
      o_walk_root  <= '0;
      o_phys_valid <= 1'b0;
      o_phys_addr  <= '0;
    end else begin
      o_walk_req   <= i_xlat_req && i_paging_en;
      o_phys_valid <= i_xlat_req && !i_paging_en;
      if (i_xlat_req) begin
        o_walk_root <= o_ptb;
        o_phys_addr <= i_lin_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hi_fetch;
    i_mem_ack && (state == TGD_STK_H);
  endsequence

  a_long_no_switch: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_task_switch && i_long_mode |=> o_gp_fault && !o_save_valid)
    else $error("long mode switch not refused");
  a_psp_address: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state == TGD_IDLE) && i_stk_req && !i_stk_ist && (i_stk_idx == 3'h0)
    |=> o_mem_addr == i_tsb_base + ext8(TGD_OFS_PSP0))
    else $error("privileged stack pointer address wrong");
  a_pair_order: assert property (@(posedge i_clock) disable iff (!i_rstn)
    s_hi_fetch |=> o_stk_done && (o_stack_ptr[63:32] == $past(i_mem_rdata))
                   && (o_stack_ptr[31:0] == $past(lo_word)))
    else $error("stack pointer halves misordered");
  a_gate_type: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_desc_valid |=> o_gate.is_task_gate == ($past(i_desc_hi[TGD_ST_MSB:TGD_ST_LSB]) == TGD_TASK_GATE))
    else $error("task gate type decode wrong");
  a_np_fault: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_desc_valid && !i_long_mode && (i_desc_hi[TGD_ST_MSB:TGD_ST_LSB] == TGD_TASK_GATE)
    && !i_desc_hi[TGD_P_BIT] |=> o_np_fault)
    else $error("absent gate not faulted");
  a_gate_fields: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_desc_valid |=> (o_gate.tsb_selector == $past(i_desc_lo[TGD_SEL_MSB:TGD_SEL_LSB]))
                     && (o_gate.descriptor_privilege_level == $past(i_desc_hi[TGD_DPL_MSB:TGD_DPL_LSB])))
    else $error("gate selector or privilege wrong");
  a_ldt_swap: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_task_switch && !i_long_mode |=> o_save_valid && (o_saved_ldt_sel == $past(o_ldt_sel))
                                      && (o_ldt_sel == $past(i_new_ldt_sel)))
    else $error("local table selector not swapped");
  a_paging_off: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_xlat_req && !i_paging_en |=> o_phys_valid && !o_walk_req && (o_phys_addr == $past(i_lin_addr)))
    else $error("unpaged address not passed through");
  a_long_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_desc_valid && i_desc_xfer && i_long_mode && (i_desc_hi[TGD_ST_MSB:TGD_ST_LSB] == TGD_TASK_GATE)
    |=> o_gp_fault && !o_np_fault)
    else $error("long mode gate transfer not faulted");
  a_io_deny: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state == TGD_IO_H) && i_mem_ack |=> o_io_done && (o_io_grant == !$past(io_deny))
                                         && (o_gp_fault == $past(io_deny)))
    else $error("io permission result wrong");
endmodule

// [sim/tgd_decoder_tb_top.sv]
// Self-checking bench for the task gate and long task state block decoder.
// Assumes tgd_mem_model answers the memory port; inputs change 1 ns after the edge.
`timescale 1ns/100ps
module tgd_decoder_tb_top
  import tgd_pkg::*;
;
  logic        clk, rstn, lmode, pg, dv, dx, sreq, sist, ioreq, ack, tsw, xreq, mreq;
  logic        gv, np, gp, busy, sdone, iodone, grant, sv, wreq, pv;
  tgd_table_t  dtab;
  tgd_gate_t   gate;
  tgd_io_req_t io;
  logic [31:0] dlo, dhi, base, rdata, maddr, nptb, lin, sptb, ptb, wroot, paddr, cur_ptb;
  logic [15:0] lim, nldt, sldt, local_descriptor_table, cur_ldt;
  logic [63:0] sp;
  logic [2:0]  sidx;
  logic [1:0]  mwait;
  int          err_count = 0;
  int          comparisons = 0;
  localparam logic [31:0] map_ofs = 32'h0000_0068;
  localparam logic [4:0]  st [4] = '{5'h15, 5'h04, 5'h0d, 5'h00};
  localparam tgd_io_req_t cs [9] = '{'{16'h0000, 3'h1}, '{16'h000d, 3'h1}, '{16'h000a, 3'h4},
    '{16'h003c, 3'h4}, '{16'h003e, 3'h4}, '{16'h003f, 3'h3}, '{16'h0040, 3'h2},
    '{16'h0070, 3'h1}, '{16'h0078, 3'h1}};

  tgd_decoder #(.ADDR_W(32)) dut_u (
    .i_clock(clk), .i_rstn(rstn), .i_long_mode(lmode), .i_paging_en(pg),
    .i_desc_valid(dv), .i_desc_xfer(dx), .i_desc_table(dtab), .i_desc_lo(dlo),
    .i_desc_hi(dhi), .i_tsb_base(base), .i_tsb_limit(lim), .i_stk_req(sreq),
    .i_stk_ist(sist), .i_stk_idx(sidx), .i_io_req(ioreq), .i_io(io),
    .o_mem_req(mreq), .o_mem_addr(maddr), .i_mem_ack(ack), .i_mem_rdata(rdata),
    .i_task_switch(tsw), .i_new_ldt_sel(nldt), .i_new_ptb(nptb), .i_xlat_req(xreq),
    .i_lin_addr(lin), .o_gate(gate), .o_gate_valid(gv), .o_np_fault(np),
    .o_gp_fault(gp), .o_busy(busy), .o_stack_ptr(sp), .o_stk_done(sdone),
    .o_io_done(iodone), .o_io_grant(grant), .o_save_valid(sv), .o_saved_ldt_sel(sldt),
    .o_saved_ptb(sptb), .o_ldt_sel(local_descriptor_table), .o_ptb(ptb), .o_walk_req(wreq),
    .o_walk_root(wroot), .o_phys_valid(pv), .o_phys_addr(paddr));

  tgd_mem_model mem_u (.i_clock(clk), .i_rstn(rstn), .i_req(mreq), .i_addr(maddr),
    .i_wait(mwait), .o_ack(ack), .o_rdata(rdata));

  always #20 clk = ~clk;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("counts: comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [31:0] word(input logic [31:0] off);
    return mem_u.mem[8'((base + off) >> 2)];
  endfunction

  // Grant expected when both bitmap bytes exist and every covered bit is clear
  function automatic logic perm_ok(input tgd_io_req_t r);
    logic [31:0] b;
    logic [15:0] two;
    int          n;
    n = (r.size == 3'h1) ? 1 : (r.size == 3'h2) ? 2 : 4;
    b = map_ofs + 32'(r.port >> 3);
    if (b + 1 > 32'(lim)) return 1'b0;
    // Second byte may sit in the next word when the first is the top byte of its word
    two = {8'(word((b + 1) & ~32'h3) >> (8 * ((b + 1) & 32'h3))), 8'(word(b & ~32'h3) >> (8 * b[1:0]))};
    return ((two >> r.port[2:0]) & 16'((1 << n) - 1)) == 16'h0;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_desc();
    tgd_gate_t e;
    logic      tg, egp, enp;
    for (int k = 0; k < 12; k++) begin
      tg = (k < 8);
      dx = k[1];
      lmode = k[2] | k[3];
      dtab = tgd_table_t'(k % 3);
      dhi = {16'ha5c3, k[0], k[2:1], tg ? 5'h05 : st[k - 8], 8'h7e};
      dlo = {8'h40 + 8'(k), 8'h18, 16'hf00f};
      e = '{k[0], k[2:1], tg, {8'h40 + 8'(k), 8'h18}, dtab};
      egp = tg & dx & lmode;
      enp = tg & !k[0] & !egp;
      dv = 1'b1;
      step();
      chk(64'(gate), 64'(e));
      chk(64'(gv), 64'h1);
      chk(64'(gp), 64'(egp));
      chk(64'(np), 64'(enp));
    end
    dv = 1'b0;
    $display("done: descriptors");
  endtask

  task automatic t_stack();
    logic [31:0] off;
    for (int k = 0; k < 10; k++) begin
      sist = (k >= 3);
      sidx = sist ? 3'(k - 2) : 3'(k);
      off = sist ? 32'h24 + 8 * (32'(sidx) - 1) : 32'h04 + 8 * 32'(sidx);
      mwait = 2'(k % 3);
      sreq = 1'b1;
      step();
      sreq = 1'b0;
      chk(64'(busy), 64'h1);
      for (int n = 0; n < 30 && sdone !== 1'b1; n++) step();
      chk(64'(sdone), 64'h1);
      chk(sp, {word(off + 4), word(off)});
      step();
    end
    $display("done: stack pointers");
  endtask

  task automatic t_io();
    for (int k = 0; k < 9; k++) begin
      io = cs[k];
      mwait = 2'(k % 3);
      ioreq = 1'b1;
      step();
      ioreq = 1'b0;
      for (int n = 0; n < 40 && iodone !== 1'b1; n++) step();
      chk(64'(iodone), 64'h1);
      chk(64'(grant), 64'(perm_ok(cs[k])));
      chk(64'(gp), 64'(!perm_ok(cs[k])));
      step();
    end
    $display("done: io permission");
  endtask

  task automatic t_switch();
    for (int k = 0; k < 4; k++) begin
      lmode = (k == 2);
      nldt = 16'h0a08 + 16'(k);
      nptb = 32'h0001_0000 << k;
      tsw = 1'b1;
      step();
      chk(64'(sv), 64'(!lmode));
      chk(64'(gp), 64'(lmode));
      if (!lmode) begin
        chk(64'({sldt, sptb}), 64'({cur_ldt, cur_ptb}));
        cur_ldt = nldt;
        cur_ptb = nptb;
      end
      chk(64'({local_descriptor_table, ptb}), 64'({cur_ldt, cur_ptb}));
    end
    tsw = 1'b0;
    $display("done: task switches");
  endtask

  task automatic t_xlat();
    for (int k = 0; k < 4; k++) begin
      pg = k[0];
      lin = 32'h7e57_0000 | 32'(k);
      xreq = 1'b1;
      step();
      chk(64'({wreq, pv}), 64'({pg, !pg}));
      chk(64'(pg ? wroot : paddr), 64'(pg ? cur_ptb : lin));
    end
    xreq = 1'b0;
    $display("done: translation");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {clk, rstn, lmode, pg, dv, dx, sreq, sist, ioreq, tsw, xreq} = '0;
    {dlo, dhi, sidx, mwait, nldt, nptb, lin, cur_ldt, cur_ptb} = '0;
    dtab = TGD_TBL_GLOBAL;
    io = '0;
    base = 32'h0000_0200;
    lim = 16'h0077;
    for (int i = 0; i < 256; i++) mem_u.mem[i] = {8'(i), 8'h3c, ~8'(i), 8'hc5};
    // Map offset with junk in the reserved low half; last bitmap byte all ones
    mem_u.mem[8'h99] = {16'h0068, 16'h5a5a};
    mem_u.mem[8'h9a] = 32'h0000_2000;
    mem_u.mem[8'h9b] = 32'h0000_0000;
    mem_u.mem[8'h9c] = 32'h0000_0001;
    mem_u.mem[8'h9d] = 32'hff00_0000;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    step();
    chk(64'({gv, np, gp, busy, sdone, iodone, sv, wreq, pv}), 64'h0);
    t_desc();
    t_stack();
    t_io();
    t_switch();
    t_xlat();
    rstn = 1'b0;
    step();
    rstn = 1'b1;
    step();
    chk(64'({local_descriptor_table, ptb}), 64'h0);
    give_verdict();
  end

  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
endmodule

// [sim/tgd_mem_model.sv]
// Memory model holding task state blocks; descriptors come on ports.
// Assumes byte addresses on i_addr, one word returned per acknowledge.
`timescale 1ns/100ps
module tgd_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  // ----------------------------------------
  // Storage and answer
  // ----------------------------------------
  // Filled by software with the 64-bit block before any fetch
  logic [31:0] mem [256];
  logic [31:0] last;
  logic [1:0]  cnt;

  assign o_ack   = i_req && (cnt == i_wait);
  // Outside an acknowledge the lines never repeat the last word
  assign o_rdata = o_ack ? mem[i_addr[9:2]] : ~last;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt  <= 2'h0;
      last <= 32'h0;
    end else begin
      cnt <= (!i_req || o_ack) ? 2'h0 : cnt + 2'h1;
      if (o_ack) begin
        last <= o_rdata;
      end
    end
  end
endmodule
